// >>> hdl/apms_pkg.sv
`default_nettype none
package apms_pkg;
  localparam int MCLK_PERIOD_NS = 100;
  localparam int SCLK_MIN_PERIOD_NS_0 = 25;
  localparam int SCLK_MIN_PERIOD_NS_1 = 50;
  localparam int SCLK_MIN_PERIOD_NS_2 = 100;
  localparam int SCLK_MIN_PERIOD_NS_3 = 200;

  // half period of the internal serial clock in mclk cycles, rounded up, at least one
  function automatic int apms_half_cycles(input int period_ns);
    int c;
    c = (period_ns + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);
    return (c < 1) ? 1 : c;
  endfunction : apms_half_cycles

  localparam int HALF_W = 8;
  localparam logic [HALF_W-1:0] SCLK_HALF_0 = HALF_W'(apms_half_cycles(SCLK_MIN_PERIOD_NS_0));
  localparam logic [HALF_W-1:0] SCLK_HALF_1 = HALF_W'(apms_half_cycles(SCLK_MIN_PERIOD_NS_1));
  localparam logic [HALF_W-1:0] SCLK_HALF_2 = HALF_W'(apms_half_cycles(SCLK_MIN_PERIOD_NS_2));
  localparam logic [HALF_W-1:0] SCLK_HALF_3 = HALF_W'(apms_half_cycles(SCLK_MIN_PERIOD_NS_3));

  localparam int RESULT_W = 16;
  localparam int WORD_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int BITCNT_W = 6;
  localparam logic [BITCNT_W-1:0] FRAME_BITS = 6'h20;

  // data bus pin positions reused by the serial port
  localparam int D_DIV_LO = 2;
  localparam int D_DIV_HI = 3;
  localparam int D_CLK_SRC = 4;
  localparam int D_FRAME_POL = 5;
  localparam int D_CLK_INV = 6;
  localparam int D_RD_TIMING = 7;
  localparam int D_SERIAL_DATA_OUT = 8;
  localparam int BYTE_W = 8;

  localparam logic [15:0] OE_PARALLEL = 16'hffff;
  localparam logic [15:0] OE_SERIAL = 16'h0100;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b100
  } apms_state_t;
endpackage : apms_pkg
`default_nettype wire

// >>> hdl/apms_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface apms_fifo_if #(
  parameter int WIDTH = 32
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : apms_fifo_if
`default_nettype wire

// >>> hdl/apms_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module apms_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  apms_fifo_if.fifo port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign port.wr_ready = (count != (AW+1)'(DEPTH));
  assign port.rd_valid = (count != '0);
  assign port.rd_data = mem[rptr];
  assign push = port.wr_valid && port.wr_ready;
  assign pop = port.rd_valid && port.rd_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= port.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : AW'(wptr + 1'b1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : AW'(rptr + 1'b1);
      end
      count <= AW'(0) + count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : apms_fifo
`default_nettype wire

// >>> hdl/apms_tick_div.sv
`timescale 1ns/100ps
`default_nettype none
module apms_tick_div #(
  parameter int CNT_W = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [CNT_W-1:0] half_cycles,
  output logic tick
);
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= CNT_W'(half_cycles - 1'b1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= CNT_W'(cnt + 1'b1);
      tick <= 1'b0;
    end
  end
endmodule : apms_tick_div
`default_nettype wire

// >>> hdl/apms_port.sv
// Contract
// - pair select low samples the first input of each channel, high the second.
// - byte order low puts the low byte on d[7:0] and high byte on d[15:8], high swaps them.
// - in parallel mode channel order low presents channel B, high channel A.
// - in serial mode channel order high shifts A then B, low shifts B then A.
// - low-power select high runs reduced-power mode, low runs normal mode.
// - port type low uses the parallel port, high the serial port on reused data pins.
// - serial mode floats data bits 0 and 1, parallel mode drives them as result bits.
// - in serial master read-after-convert data bits 2 and 3 form the clock divider code.
// - every other serial mode ignores the divider inputs.
// - serial with clock source low is master and drives the internal serial clock.
// - serial with clock source high is slave and shifts on the host's serial clock.
// - frame is active high when frame polarity is low and active low when high.
// - divider codes 0 to 3 give least serial clock periods of 25, 50, 100, 200 ns.
// - internal clocking reads during conversion when read timing is high, after it when low.
// - the clock invert input flips the serial clock sense in master and slave modes.
// - both results sit in a 32-bit shift register sent most significant bit first.
`timescale 1ns/100ps
`default_nettype none
module apms_port
  import apms_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic input_pair_select,
  input wire logic byte_lane_order,
  input wire logic chan_order_select,
  input wire logic low_power_select,
  input wire logic port_type_select,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic frame_out,
  output logic frame_oe,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic result_valid,
  input wire logic [RESULT_W-1:0] chan_a_result,
  input wire logic [RESULT_W-1:0] chan_b_result,
  output logic result_ready,
  output logic mux_second_pair,
  output logic reduced_power
);
  localparam int SYNC_W = 12;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic pair_s;
  logic byte_order_s;
  logic chan_order_s;
  logic low_power_s;
  logic serial_mode;
  logic [1:0] div_code_s;
  logic clk_src_s;
  logic frame_pol_s;
  logic clk_inv_s;
  logic rd_timing_s;
  logic sclk_s;
  logic sclk_eff_d;

  apms_fifo_if #(.WIDTH(WORD_W)) fq ();

  // results queue: channel A in the upper half
  // a full queue holds the core off rather than losing a result
  assign fq.wr_valid = result_valid;
  assign fq.wr_data = {chan_a_result, chan_b_result};
  assign result_ready = fq.wr_ready;

  apms_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .port(fq)
  );

  // pins come from the host's domain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {port_type_select, low_power_select, chan_order_select, byte_lane_order,
                input_pair_select, data_in[D_RD_TIMING:D_DIV_LO], sclk_in};
      sync2 <= sync1;
    end
  end

  assign sclk_s = sync2[0];
  assign div_code_s = sync2[D_DIV_HI-1:D_DIV_LO-1];
  assign clk_src_s = sync2[D_CLK_SRC-1];
  assign frame_pol_s = sync2[D_FRAME_POL-1];
  assign clk_inv_s = sync2[D_CLK_INV-1];
  assign rd_timing_s = sync2[D_RD_TIMING-1];
  assign pair_s = sync2[7];
  assign byte_order_s = sync2[8];
  assign chan_order_s = sync2[9];
  assign low_power_s = sync2[10];
  assign serial_mode = sync2[11];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mux_second_pair <= 1'b0;
      reduced_power <= 1'b0;
    end else begin
      mux_second_pair <= pair_s;
      reduced_power <= low_power_s;
    end
  end

  logic master;
  logic slave;
  logic master_rac;
  logic [HALF_W-1:0] half_sel;

  assign master = serial_mode && !clk_src_s;
  assign slave = serial_mode && clk_src_s;
  assign master_rac = master && !rd_timing_s;

  // the divider code only matters in master read-after-convert
  always_comb begin
    half_sel = SCLK_HALF_0;
    if (master_rac) begin
      case (div_code_s)
        2'b00: half_sel = SCLK_HALF_0;
        2'b01: half_sel = SCLK_HALF_1;
        2'b10: half_sel = SCLK_HALF_2;
        default: half_sel = SCLK_HALF_3;
      endcase
    end
  end

  apms_state_t state;
  logic [WORD_W-1:0] shreg;
  logic [BITCNT_W-1:0] bits_left;
  logic sclk_level;
  logic div_tick;
  logic frame_active;
  logic start_ok;
  logic ser_pop;
  logic par_pop;
  logic shift_ev;
  logic [WORD_W-1:0] order_word;

  assign frame_active = (state == ST_SHIFT);

  // at 10 MHz every code rounds up to one cycle a half, slower than the fastest code allows
  apms_tick_div #(.CNT_W(HALF_W)) u_div (
    .mclk(mclk),
    .resetn(resetn),
    .run(frame_active && master),
    .half_cycles(half_sel),
    .tick(div_tick)
  );

  // start of a serial read
  always_comb begin
    start_ok = 1'b0;
    if (master && !rd_timing_s) begin
      start_ok = !conv_busy;
    end else if (master) begin
      start_ok = conv_start;
    end else if (slave) begin
      start_ok = 1'b1;
    end
  end

  assign ser_pop = serial_mode && (state == ST_IDLE) && fq.rd_valid && start_ok;
  assign par_pop = !serial_mode && fq.rd_valid;
  assign fq.rd_ready = ser_pop || par_pop;

  // order of channels on the wire
  assign order_word = chan_order_s ? fq.rd_data
                                   : {fq.rd_data[RESULT_W-1:0], fq.rd_data[WORD_W-1:RESULT_W]};

  // slave shifts on the falling edge of the effective host clock
  // the sync chain costs two cycles, so the host clock must stay slow against mclk
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_eff_d <= 1'b0;
    end else begin
      sclk_eff_d <= sclk_s ^ clk_inv_s;
    end
  end

  always_comb begin
    shift_ev = 1'b0;
    if (master) begin
      shift_ev = div_tick && sclk_level;
    end else if (slave) begin
      shift_ev = sclk_eff_d && !(sclk_s ^ clk_inv_s);
    end
  end

  // mode pins are read live, a change mid-frame is the host's fault
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      shreg <= '0;
      bits_left <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ser_pop) begin
            shreg <= order_word;
            bits_left <= FRAME_BITS;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!serial_mode) begin
            state <= ST_GAP;
          end else if (shift_ev) begin
            shreg <= {shreg[WORD_W-2:0], 1'b0};
            bits_left <= BITCNT_W'(bits_left - 1'b1);
            if (bits_left == BITCNT_W'(1)) begin
              state <= ST_GAP;
            end
          end
        end
        ST_GAP: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_level <= 1'b0;
    end else if (!frame_active || !master) begin
      sclk_level <= 1'b0;
    end else if (div_tick) begin
      sclk_level <= !sclk_level;
    end
  end

  // parallel output word, refreshed on each parallel-mode pop
  logic [15:0] par_out;
  logic [15:0] next_par_out;
  logic [RESULT_W-1:0] chosen;

  always_comb begin
    chosen = chan_order_s ? fq.rd_data[WORD_W-1:RESULT_W] : fq.rd_data[RESULT_W-1:0];
    next_par_out = byte_order_s ? {chosen[BYTE_W-1:0], chosen[15:BYTE_W]} : chosen;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      par_out <= '0;
    end else if (par_pop) begin
      par_out <= next_par_out;
    end
  end

  always_comb begin
    data_out = par_out;
    data_oe = OE_PARALLEL;
    if (serial_mode) begin
      data_out = '0;
      data_out[D_SERIAL_DATA_OUT] = shreg[WORD_W-1];
      data_oe = OE_SERIAL;
    end
  end

  assign sclk_out = master ? (sclk_level ^ clk_inv_s) : 1'b0;
  assign sclk_oe = master;
  assign frame_out = serial_mode ? (frame_active ^ frame_pol_s) : 1'b0;
  assign frame_oe = serial_mode;

  // checking helpers
  logic [BITCNT_W:0] shift_total;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_total <= '0;
    end else if (ser_pop) begin
      shift_total <= '0;
    end else if (frame_active && shift_ev) begin
      shift_total <= (BITCNT_W+1)'(shift_total + 1'b1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence frame_start_s;
    ser_pop ##1 frame_active;
  endsequence

  // a frame that runs out on its own, not one cut short by a mode change
  sequence frame_end_s;
    (frame_active && serial_mode) ##1 (state == ST_GAP);
  endsequence

  serial_lanes_float_a: assert property (serial_mode |-> data_oe[1:0] == 2'b00)
    else $error("data bits 0 and 1 driven in serial mode");
  par_lanes_drive_a: assert property (!serial_mode |-> data_oe == OE_PARALLEL)
    else $error("parallel bus not fully driven");
  par_chan_b_a: assert property ((par_pop && !byte_order_s && !chan_order_s)
    |=> par_out == $past(fq.rd_data[RESULT_W-1:0]))
    else $error("channel B not presented in parallel mode");
  par_chan_a_a: assert property ((par_pop && !byte_order_s && chan_order_s)
    |=> par_out == $past(fq.rd_data[WORD_W-1:RESULT_W]))
    else $error("channel A not presented in parallel mode");
  par_byte_swap_a: assert property ((par_pop && byte_order_s && chan_order_s)
    |=> par_out == {$past(fq.rd_data[23:16]), $past(fq.rd_data[31:24])})
    else $error("byte lanes not exchanged");
  serial_order_a: assert property (ser_pop && !chan_order_s
    |=> shreg == {$past(fq.rd_data[15:0]), $past(fq.rd_data[31:16])})
    else $error("channel order wrong at frame load");
  serial_order_hi_a: assert property (ser_pop && chan_order_s
    |=> shreg == $past(fq.rd_data))
    else $error("channel A not first at frame load");
  power_mode_a: assert property (##2 reduced_power == $past(low_power_select, 3))
    else $error("power mode does not follow its pin");
  pair_select_a: assert property (##2 mux_second_pair == $past(input_pair_select, 3))
    else $error("pair select does not follow its pin");
  master_sclk_drive_a: assert property (master
    |-> sclk_oe && (sclk_out == (sclk_level ^ clk_inv_s)))
    else $error("master does not drive the serial clock");
  slave_sclk_float_a: assert property (!master |-> !sclk_oe)
    else $error("slave drives the serial clock");
  frame_polarity_a: assert property (serial_mode
    |-> (frame_out != frame_pol_s) == (state == ST_SHIFT))
    else $error("frame polarity wrong");
  divider_ignored_a: assert property (!master_rac |-> half_sel == SCLK_HALF_0)
    else $error("divider code used outside master read-after-convert");
  divider_table_a: assert property (master_rac && div_code_s == 2'b11
    |-> half_sel == SCLK_HALF_3)
    else $error("divider code 3 gives wrong clock");
  divider_code1_a: assert property (master_rac && div_code_s == 2'b01
    |-> half_sel == SCLK_HALF_1)
    else $error("divider code 1 gives wrong clock");
  divider_code2_a: assert property (master_rac && div_code_s == 2'b10
    |-> half_sel == SCLK_HALF_2)
    else $error("divider code 2 gives wrong clock");
  rac_waits_a: assert property (ser_pop && master |-> rd_timing_s || !conv_busy)
    else $error("read during conversion without read timing high");
  read_on_start_a: assert property (ser_pop && master && rd_timing_s |-> conv_start)
    else $error("read during conversion began without a start");
  frame_load_a: assert property (frame_start_s |-> bits_left == FRAME_BITS)
    else $error("frame not loaded with 32 bits to send");
  frame_bits_a: assert property (frame_end_s
    |-> shift_total == (BITCNT_W+1)'(FRAME_BITS))
    else $error("frame did not carry 32 bits");
endmodule : apms_port
`default_nettype wire

// >>> dv/apms_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module apms_host_model (
  input wire logic mclk,
  input wire logic master,
  input wire logic inv,
  input wire logic pol,
  input wire logic sclk_out,
  input wire logic sdo,
  input wire logic frame_out,
  input wire logic frame_oe,
  output logic sclk_in,
  output logic [31:0] word,
  output logic [5:0] nbits,
  output logic [7:0] period
);
  logic lvl = 1'b0;
  logic prev_e = 1'b0;
  logic prev_act = 1'b0;
  logic [3:0] hc = 4'h0;
  logic [7:0] since = 8'h00;
  logic act;
  logic e;
  assign act = frame_oe && (frame_out ^ pol);
  // idle level follows the invert pin so the device never sees a stray edge
  assign sclk_in = lvl ^ inv;
  assign e = master ? (sclk_out ^ inv) : lvl;
  initial begin
    word = 32'h0000_0000;
    nbits = 6'h00;
    period = 8'h00;
  end
  always @(posedge mclk) begin
    // host clock only runs within a frame, kept slow against mclk
    if (!master && act) begin
      hc <= hc + 4'h1;
      if (hc == 4'h7) begin
        lvl <= ~lvl;
      end
    end else begin
      hc <= 4'h0;
      lvl <= 1'b0;
    end
    prev_e <= e;
    prev_act <= act;
    since <= since + 8'h01;
    if (act && !prev_act) begin
      nbits <= 6'h00;
    end else if (act && e && !prev_e) begin
      word <= {word[30:0], sdo};
      nbits <= nbits + 6'h01;
      period <= since;
      since <= 8'h01;
    end
  end
endmodule : apms_host_model
`default_nettype wire

// >>> dv/test_adc_port_mode_select.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_port_mode_select;
  import apms_pkg::*;
  logic mclk = 0, resetn = 0, pair = 0, swap = 0, order = 0, lp = 0, ser = 0, src = 0;
  logic rdt = 0, pol = 0, inv = 0, conv_start = 0, conv_busy = 0, valid = 0;
  logic [1:0] div = 2'b00;
  logic [15:0] a = 16'h0000, b = 16'h0000, data_out, data_oe;
  logic sclk_out, sclk_oe, frame_out, frame_oe, ready, mux2, rp, sclk_in;
  logic [31:0] host_word;
  logic [5:0] host_nbits;
  logic [7:0] host_period;
  logic [31:0] rnd = 32'h0000_dcbd;
  logic [31:0] q[$];
  int errors = 0, n_checks = 0, cycles = 0;
  int ns[4] = '{25, 50, 100, 200};
  wire logic [15:0] pins = {8'h00, rdt, inv, pol, src, div, 2'b00};
  wire logic [15:0] data_in = (data_out & data_oe) | (pins & ~data_oe);
  wire logic in_frame = frame_oe && (frame_out ^ pol);

  always #50 mclk = ~mclk;

  apms_port apms_port_inst (.mclk(mclk), .resetn(resetn), .input_pair_select(pair),
    .byte_lane_order(swap), .chan_order_select(order), .low_power_select(lp),
    .port_type_select(ser), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_out(frame_out),
    .frame_oe(frame_oe), .conv_start(conv_start), .conv_busy(conv_busy),
    .result_valid(valid), .chan_a_result(a), .chan_b_result(b), .result_ready(ready),
    .mux_second_pair(mux2), .reduced_power(rp));

  apms_host_model apms_host_model_inst (.mclk(mclk), .master(!src), .inv(inv), .pol(pol),
    .sclk_out(sclk_out), .sdo(data_out[8]), .frame_out(frame_out), .frame_oe(frame_oe),
    .sclk_in(sclk_in), .word(host_word), .nbits(host_nbits), .period(host_period));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [15:0] par_exp(input logic [15:0] x, y, input logic o, w);
    logic [15:0] c;
    c = o ? x : y;
    return w ? {c[7:0], c[15:8]} : c;
  endfunction : par_exp

  // half period is half the minimum period rounded up to whole mclk cycles, returned doubled as the full period
  function automatic int sclk_cyc(input int p);
    int h;
    h = (p + 199) / 200;
    return 2 * ((h < 1) ? 1 : h);
  endfunction : sclk_cyc

  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic mode(input logic s, c, r, p, i, o, w, input logic [1:0] d);
    @(negedge mclk);
    ser = s;
    src = c;
    rdt = r;
    pol = p;
    inv = i;
    order = o;
    swap = w;
    div = d;
    repeat (4) @(negedge mclk);
  endtask : mode

  task automatic push(input logic [15:0] x, y);
    int n;
    n = 0;
    @(negedge mclk);
    valid = 1;
    a = x;
    b = y;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask : push

  task automatic stop();
    @(negedge mclk);
    valid = 0;
  endtask : stop

  task automatic get_frame(input logic [31:0] e);
    int n;
    n = 0;
    while (in_frame !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    while (in_frame !== 1'b0 && n < 1200) begin
      @(negedge mclk);
      n++;
    end
    chk(host_word, e);
    chk(host_nbits, 32);
  endtask : get_frame

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    @(negedge mclk);
    chk(data_oe, 16'hffff);
    chk({sclk_oe, frame_oe, ready}, 3'b001);
    repeat (2) @(negedge mclk);
    resetn = 1;
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      pair = i[0];
      lp = i[1];
      repeat (4) @(negedge mclk);
      chk(mux2, pair);
      chk(rp, lp);
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      mode(0, rnd[0], rnd[1], rnd[2], rnd[3], i[0], i[1], rnd[5:4]);
      push(rnd[15:0], rnd[31:16]);
      stop();
      repeat (4) @(negedge mclk);
      chk(data_out, par_exp(a, b, order, swap));
      chk(data_oe, 16'hffff);
    end
    // fill the buffer while the converter is busy, then drain it
    conv_busy = 1;
    rnd = lfsr(rnd);
    mode(1, 0, 0, rnd[0], rnd[1], rnd[2], 0, rnd[4:3]);
    chk(sclk_oe, 1);
    chk(data_oe, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      push(rnd[15:0], rnd[31:16]);
      q.push_back(order ? {a, b} : {b, a});
    end
    @(negedge mclk);
    chk(ready, 0);
    valid = 0;
    conv_busy = 0;
    for (int i = 0; i < 4; i++) begin
      get_frame(q.pop_front());
    end
    chk(ready, 1);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      mode(1, 1, rnd[3], i[2], i[1], i[0], 0, rnd[5:4]);
      chk(frame_out, pol);
      chk(sclk_oe, 0);
      push(rnd[31:16], rnd[15:0]);
      stop();
      get_frame(order ? {a, b} : {b, a});
    end
    for (int d = 0; d < 4; d++) begin
      rnd = lfsr(rnd);
      mode(1, 0, 1, rnd[0], rnd[1], rnd[2], 0, d[1:0]);
      push(rnd[15:0], rnd[31:16]);
      stop();
      repeat (6) @(negedge mclk);
      chk(in_frame, 0);
      conv_start = 1;
      @(negedge mclk);
      conv_start = 0;
      get_frame(order ? {a, b} : {b, a});
      chk(host_period, sclk_cyc(ns[d]));
    end
    end_of_test();
  end
endmodule : test_adc_port_mode_select
`default_nettype wire
